// ---- iar_pkg.sv ----
// Shared constants, types and decode function for the interrupt acknowledgement relay
package iar_pkg;
    localparam int IAR_ID_W = 5;
    localparam int IAR_MAX_BITS = 32;
    localparam int IAR_PORTS = 4;
    localparam int IAR_INTERVAL_W = 24;
    localparam int IAR_CLK_PERIOD_NS = 20;
    localparam logic [IAR_MAX_BITS-1:0] IAR_RELAY_RESET = 32'h0;
    localparam logic [IAR_INTERVAL_W-1:0] IAR_COUNT_RESET = 24'h0;
    localparam logic [IAR_INTERVAL_W-1:0] IAR_COUNT_LAST = 24'h1;

    typedef enum logic
    {
        IAR_KIND_INT = 1'b0,
        IAR_KIND_ACK = 1'b1
    } iar_kind_t;

    typedef enum logic
    {
        IAR_TMR_IDLE = 1'b0,
        IAR_TMR_RUN = 1'b1
    } iar_tmr_state_t;

    // One-hot select of a relay bit from an identifier
    function automatic logic [IAR_MAX_BITS-1:0] iar_bit_select(input logic [IAR_ID_W-1:0] id);
        iar_bit_select = {{(IAR_MAX_BITS-1){1'b0}}, 1'b1} << id;
    endfunction
endpackage

// ---- iar_tmr_if.sv ----
// Control bundle between the relay logic and its bank of time-out timers
`timescale 1ns/1ps
interface iar_tmr_if #(parameter int NBITS = 32);
    logic [NBITS-1:0] start;
    logic [NBITS-1:0] stop;
    logic [NBITS-1:0] expire;
    logic [iar_pkg::IAR_INTERVAL_W-1:0] interval;
    modport relay (output start, output stop, output interval, input expire);
    modport bank (input start, input stop, input interval, output expire);
endinterface

// ---- iar_tmr_bank.sv ----
// One independent time-out timer per relay register bit
`timescale 1ns/1ps
module iar_tmr_bank #(parameter int NBITS = 32)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Timer control
    iar_tmr_if.bank tmr
);
    import iar_pkg::*;

    // Zero interval is loaded as one cycle; the count compare would expire it after one cycle anyway
    logic [IAR_INTERVAL_W-1:0] load_val;
    assign load_val = (tmr.interval == IAR_COUNT_RESET) ? IAR_COUNT_LAST : tmr.interval;

    genvar g;
    generate
        for (g = 0; g < NBITS; g++)
        begin : g_tmr
            iar_tmr_state_t state;
            logic [IAR_INTERVAL_W-1:0] count;
            // A stop in the same cycle suppresses the expiry
            assign tmr.expire[g] = (state == IAR_TMR_RUN) && (count <= IAR_COUNT_LAST) && !tmr.stop[g];
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    state <= IAR_TMR_IDLE;
                    count <= IAR_COUNT_RESET;
                end
                else if (tmr.stop[g])
                begin
                    state <= IAR_TMR_IDLE;
                    count <= load_val;
                end
                else if (tmr.start[g])
                begin
                    state <= IAR_TMR_RUN;
                    count <= load_val;
                end
                else if (state == IAR_TMR_RUN)
                begin
                    state <= (count <= IAR_COUNT_LAST) ? IAR_TMR_IDLE : IAR_TMR_RUN;
                    count <= count - IAR_COUNT_LAST;
                end
            end
        end
    endgenerate
endmodule

// ---- iar_rx_arb.sv ----
// Fixed-priority pick of one arriving code per cycle
`timescale 1ns/1ps
module iar_rx_arb #(parameter int PORTS = 4, parameter int PW = 2)
(
    // Requests
    input wire logic [PORTS-1:0] req,
    // Winner
    output logic [PORTS-1:0] grant,
    output logic [PW-1:0] index,
    output logic any
);
    // Lowest port wins; the taken mask in the relay keeps one port from holding it twice in a row
    always_comb
    begin
        grant = '0;
        index = '0;
        for (int i = PORTS - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                grant = '0;
                grant[i] = 1'b1;
                index = PW'(i);
            end
        end
    end

    assign any = |req;
endmodule

// ---- iar_relay.sv ----
// Interrupt and acknowledgement relay of a routing switch
`timescale 1ns/1ps
module iar_relay
    import iar_pkg::*;
#(
    parameter int PORTS = iar_pkg::IAR_PORTS,
    parameter int RELAY_BITS = iar_pkg::IAR_MAX_BITS
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Configuration
    input wire logic ACK_MODE_EN,
    input wire logic [iar_pkg::IAR_INTERVAL_W-1:0] INT_MODE_TIMEOUT_INTERVAL,
    input wire logic [iar_pkg::IAR_INTERVAL_W-1:0] ACK_MODE_TIMEOUT_INTERVAL,
    input wire logic [PORTS-1:0] RX_INT_EN,
    input wire logic [PORTS-1:0] TX_INT_EN,
    input wire logic [PORTS-1:0] RX_ACK_EN,
    input wire logic [PORTS-1:0] TX_ACK_EN,
    // Codes arriving from the ports
    input wire logic [PORTS-1:0] RX_VALID,
    input wire logic [PORTS-1:0] RX_KIND,
    input wire logic [PORTS-1:0][iar_pkg::IAR_ID_W-1:0] RX_ID,
    output logic [PORTS-1:0] RX_TAKEN,
    // Codes leaving through the ports
    output logic [PORTS-1:0] TX_VALID,
    output logic [PORTS-1:0] TX_KIND,
    output logic [PORTS-1:0][iar_pkg::IAR_ID_W-1:0] TX_ID,
    // Relay state
    output logic [RELAY_BITS-1:0] RELAY_STATE
);
    import iar_pkg::*;

    localparam int PW = (PORTS > 1) ? $clog2(PORTS) : 1;

    logic [RELAY_BITS-1:0] relay;
    logic [RELAY_BITS-1:0] next_relay;
    logic [PORTS-1:0] taken;
    logic [PORTS-1:0] grant;
    logic [PW-1:0] sel_port;
    logic sel_any;

    iar_tmr_if #(.NBITS(RELAY_BITS)) tmr ();

    // Arrival selection
    wire [PORTS-1:0] pending = RX_VALID & ~taken;

    iar_rx_arb #(.PORTS(PORTS), .PW(PW)) u_arb
    (
        .req(pending),
        .grant(grant),
        .index(sel_port),
        .any(sel_any)
    );

    iar_tmr_bank #(.NBITS(RELAY_BITS)) u_tmr
    (
        .clk(CLK),
        .nrst(NRST),
        .tmr(tmr)
    );

    // Decode of the selected code
    wire sel_ack = (RX_KIND[sel_port] == IAR_KIND_ACK);
    wire [IAR_ID_W-1:0] sel_id = RX_ID[sel_port];
    wire [IAR_MAX_BITS-1:0] sel_onehot = iar_bit_select(sel_id);
    wire [RELAY_BITS-1:0] sel_bit = sel_onehot[RELAY_BITS-1:0];
    wire sel_exists = (int'(sel_id) < RELAY_BITS);

    // Receive gating; acknowledgements need the mode and the port's own enable
    wire ack_rx_ok = ACK_MODE_EN & RX_ACK_EN[sel_port];
    wire rx_allowed = sel_ack ? ack_rx_ok : RX_INT_EN[sel_port];
    wire valid_code = sel_any & rx_allowed & sel_exists;
    wire bit_now = |(relay & sel_bit);

    // Set on a fresh interrupt, clear on an acknowledgement of a live one
    wire do_set = valid_code & !sel_ack & !bit_now;
    wire do_clear = valid_code & sel_ack & bit_now;

    // Flood mask excludes the arrival port and send-disabled ports
    wire [PORTS-1:0] send_en = sel_ack ? TX_ACK_EN : TX_INT_EN;
    wire [PORTS-1:0] flood = (do_set | do_clear) ? (send_en & ~grant) : '0;

    wire [RELAY_BITS-1:0] set_mask = do_set ? sel_bit : '0;
    wire [RELAY_BITS-1:0] clr_mask = do_clear ? sel_bit : '0;

    // Expiry and ack clear first, so a set in the same cycle is never lost
    assign next_relay = (relay & ~tmr.expire & ~clr_mask) | set_mask;

    // Timer control
    assign tmr.start = set_mask;
    assign tmr.stop = clr_mask;
    assign tmr.interval = ACK_MODE_EN ? ACK_MODE_TIMEOUT_INTERVAL : INT_MODE_TIMEOUT_INTERVAL;

    // Relay register
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            relay <= IAR_RELAY_RESET[RELAY_BITS-1:0];
        end
        else
        begin
            relay <= next_relay;
        end
    end

    // Arrival handshake: every picked code is consumed, kept or dropped
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            taken <= '0;
        end
        else
        begin
            taken <= grant;
        end
    end

    // Outgoing codes, one-cycle pulses; no back-pressure from the links is assumed
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            TX_VALID <= '0;
            TX_KIND <= '0;
            TX_ID <= '0;
        end
        else
        begin
            TX_VALID <= flood;
            if (|flood)
            begin
                TX_KIND <= {PORTS{sel_ack}};
                TX_ID <= {PORTS{sel_id}};
            end
        end
    end

    assign RX_TAKEN = taken;
    assign RELAY_STATE = relay;

    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence s_ack_clear;
        do_clear;
    endsequence

    sequence s_int_set;
        do_set;
    endsequence

    sequence s_ack_dropped;
        sel_any && sel_ack && !ack_rx_ok;
    endsequence

    a_ack_mode_drop: assert property (
        sel_any && sel_ack && !ACK_MODE_EN |=> TX_VALID == '0 && (relay & $past(sel_bit)) == ($past(relay) & $past(sel_bit) & ~$past(tmr.expire)))
        else $error("acknowledgement relayed while mode unsupported");

    a_rx_ack_disabled: assert property (
        s_ack_dropped |=> TX_VALID == '0 && relay == ($past(relay) & ~$past(tmr.expire)))
        else $error("disabled port acknowledgement changed state");

    a_tx_ack_gate: assert property (
        (TX_VALID & TX_KIND & ~$past(TX_ACK_EN)) == '0)
        else $error("acknowledgement sent on send-disabled port");

    a_nonexist_drop: assert property (
        sel_any && !sel_exists |=> TX_VALID == '0)
        else $error("code for missing relay bit forwarded");

    a_ack_clears_bit: assert property (
        s_ack_clear |=> (relay & $past(sel_bit)) == '0)
        else $error("acknowledgement did not clear relay bit");

    a_ack_flood_set: assert property (
        s_ack_clear |=> TX_VALID == ($past(TX_ACK_EN) & ~$past(grant)) && TX_KIND == {PORTS{1'b1}} && TX_ID[0] == $past(sel_id))
        else $error("acknowledgement flood set wrong");

    a_timer_reloaded: assert property (
        s_ack_clear ##1 (relay & $past(sel_bit)) == '0 |-> (tmr.expire & $past(sel_bit)) == '0)
        else $error("timer expired right after acknowledgement");

    a_ack_ignored: assert property (
        valid_code && sel_ack && !bit_now |=> TX_VALID == '0 && relay == ($past(relay) & ~$past(tmr.expire)))
        else $error("acknowledgement of clear bit was not ignored");

    a_expiry_clears: assert property (
        (|tmr.expire) && !do_set |=> (relay & $past(tmr.expire)) == '0)
        else $error("expired bit still set");

    a_reset_clears: assert property (
        @(posedge CLK) disable iff (1'b0) !NRST |=> RELAY_STATE == '0)
        else $error("relay register not cleared by reset");

    a_int_sets_bit: assert property (
        s_int_set |=> (relay & $past(sel_bit)) != '0 && TX_VALID == ($past(TX_INT_EN) & ~$past(grant)))
        else $error("interrupt did not set bit and flood");

    a_int_dup_drop: assert property (
        valid_code && !sel_ack && bit_now |=> TX_VALID == '0)
        else $error("duplicate interrupt forwarded");

    sequence s_code_dropped;
        sel_any && !valid_code;
    endsequence

    sequence s_int_refused;
        sel_any && !sel_ack && !RX_INT_EN[sel_port];
    endsequence

    a_dropped_no_send: assert property (
        s_code_dropped |=> TX_VALID == '0)
        else $error("dropped code was forwarded");

    a_int_rx_disabled: assert property (
        s_int_refused |=> TX_VALID == '0 && relay == ($past(relay) & ~$past(tmr.expire)))
        else $error("disabled port interrupt changed state");

    a_no_echo: assert property (
        (TX_VALID & RX_TAKEN) == '0)
        else $error("code sent back to its arrival port");

    a_take_onehot: assert property (
        $onehot0(RX_TAKEN))
        else $error("more than one code taken in a cycle");

    a_tx_int_gate: assert property (
        (TX_VALID & ~TX_KIND & ~$past(TX_INT_EN)) == '0)
        else $error("interrupt sent on send-disabled port");

    a_tx_kind_same: assert property (
        TX_VALID != '0 |-> TX_KIND == '0 || TX_KIND == '1)
        else $error("mixed kinds in one flood");

    a_tx_id_exists: assert property (
        TX_VALID != '0 |-> int'(TX_ID[0]) < RELAY_BITS)
        else $error("flood for identifier without relay bit");

    a_tx_id_stable: assert property (
        TX_VALID == '0 |-> $stable(TX_ID) && $stable(TX_KIND))
        else $error("code fields changed without a flood");

    a_set_from_code: assert property (
        ((relay & ~$past(relay)) & ~$past(set_mask)) == '0)
        else $error("relay bit set without an interrupt");

    a_clear_has_cause: assert property (
        (($past(relay) & ~relay) & ~$past(tmr.expire) & ~$past(clr_mask)) == '0)
        else $error("relay bit cleared without acknowledgement or expiry");

    a_expiry_only_live: assert property (
        (tmr.expire & ~relay) == '0)
        else $error("timer expired for a clear relay bit");

    a_stop_live: assert property (
        (tmr.stop & ~relay) == '0)
        else $error("timer stopped for a clear relay bit");

    a_ack_needs_mode: assert property (
        TX_VALID != '0 && TX_KIND[0] |-> $past(ACK_MODE_EN))
        else $error("acknowledgement sent while mode unsupported");

    a_ack_needs_rx_en: assert property (
        TX_VALID != '0 && TX_KIND[0] |-> ($past(RX_ACK_EN) & RX_TAKEN) != '0)
        else $error("acknowledgement taken from a receive-disabled port");

    a_int_needs_rx_en: assert property (
        TX_VALID != '0 && !TX_KIND[0] |-> ($past(RX_INT_EN) & RX_TAKEN) != '0)
        else $error("interrupt taken from a receive-disabled port");

    a_ack_flood_live: assert property (
        TX_VALID != '0 && TX_KIND[0] |-> ($past(relay) & ~relay) != '0)
        else $error("acknowledgement forwarded without clearing a bit");

    a_int_flood_live: assert property (
        TX_VALID != '0 && !TX_KIND[0] |-> (relay & ~$past(relay)) != '0)
        else $error("interrupt forwarded without setting a bit");

    a_taken_from_valid: assert property (
        (RX_TAKEN & ~$past(RX_VALID)) == '0)
        else $error("code taken from an idle port");
endmodule

// ---- iar_port_model.sv ----
// Model of the neighbouring ports that present codes to the relay
`timescale 1ns/1ps
module iar_port_model
    import iar_pkg::*;
#(
    parameter int PORTS = 4
)
(
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic [PORTS-1:0] send,
    input wire logic [PORTS-1:0] send_kind,
    input wire logic [PORTS-1:0][IAR_ID_W-1:0] send_id,
    // Code lines towards the relay
    input wire logic [PORTS-1:0] rx_taken,
    output logic [PORTS-1:0] rx_valid,
    output logic [PORTS-1:0] rx_kind,
    output logic [PORTS-1:0][IAR_ID_W-1:0] rx_id
);
    initial
    begin
        rx_valid = '0;
        rx_kind = '0;
        rx_id = '0;
    end
    // Released lines show the inverse of the last code, so a stale code never matches by luck
    always @(posedge clk)
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            if (rx_valid[p] && rx_taken[p])
            begin
                rx_valid[p] <= 1'h0;
                rx_kind[p] <= ~rx_kind[p];
                rx_id[p] <= ~rx_id[p];
            end
            else if (send[p] && !rx_valid[p])
            begin
                rx_valid[p] <= 1'h1;
                rx_kind[p] <= send_kind[p];
                rx_id[p] <= send_id[p];
            end
        end
    end
endmodule

// ---- test_interrupt_ack_relay.sv ----
// Self-checking bench for the interrupt acknowledgement relay
`timescale 1ns/1ps
module test_interrupt_ack_relay;
    import iar_pkg::*;
    localparam int NB = 16;
    // Intervals in clock cycles; an acknowledgement follows its interrupt by at most six cycles here
    localparam int T_INT = 9;
    localparam int T_ACK = 16;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic ack_mode = 1'h1;
    logic [3:0] rx_ack_en = 4'hf;
    logic [3:0] rx_int_en = 4'hf;
    logic [3:0] tx_int_en = 4'h7;
    logic [3:0] tx_ack_en = 4'hb;
    logic [IAR_INTERVAL_W-1:0] int_ivl = IAR_INTERVAL_W'(T_INT);
    logic [IAR_INTERVAL_W-1:0] ack_ivl = IAR_INTERVAL_W'(T_ACK);
    logic [3:0] send = 4'h0;
    logic [3:0] send_kind = 4'h0;
    logic [3:0][IAR_ID_W-1:0] send_id = '0;
    logic [3:0] rx_valid, rx_kind, rx_taken, tx_valid, tx_kind, got;
    logic [3:0][IAR_ID_W-1:0] rx_id, tx_id;
    logic [NB-1:0] relay;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int len;

    always #10 clk = ~clk;

    iar_port_model #(.PORTS(4)) u_far (.clk(clk), .send(send), .send_kind(send_kind), .send_id(send_id),
        .rx_taken(rx_taken), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_id(rx_id));

    // Intervals kept far above the bench's own round trip
    iar_relay #(.PORTS(4), .RELAY_BITS(NB)) u_dut (.CLK(clk), .NRST(nrst), .ACK_MODE_EN(ack_mode),
        .INT_MODE_TIMEOUT_INTERVAL(int_ivl), .ACK_MODE_TIMEOUT_INTERVAL(ack_ivl), .RX_INT_EN(rx_int_en),
        .TX_INT_EN(tx_int_en), .RX_ACK_EN(rx_ack_en), .TX_ACK_EN(tx_ack_en), .RX_VALID(rx_valid),
        .RX_KIND(rx_kind),
        .RX_ID(rx_id), .RX_TAKEN(rx_taken), .TX_VALID(tx_valid), .TX_KIND(tx_kind), .TX_ID(tx_id),
        .RELAY_STATE(relay));

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'h1)
        begin
            n_mismatch++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask

    // Present one code and keep the flood pattern seen with its take pulse
    task automatic put(input int p, input logic k, input int id);
        send_kind[p] = k;
        send_id[p] = id[IAR_ID_W-1:0];
        send[p] = 1'h1;
        got = 4'hx;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #1;
            send[p] = 1'h0;
            if (rx_taken[p] === 1'h1)
            begin
                got = tx_valid;
                break;
            end
        end
        chk(got !== 4'hx, "no take pulse");
        @(posedge clk);
        #1;
    endtask

    // Cycles a relay bit stays set, counted from the edge that set it
    task automatic hold(input int id);
        len = 1;
        while (relay[id] === 1'h1 && len < 40)
        begin
            len++;
            @(posedge clk);
            #1;
        end
    endtask

    task automatic t_flow();
        chk(relay === '0 && tx_valid === 4'h0, "reset state");
        put(0, 1'h0, 3);
        chk(got === 4'h6 && relay === 16'h0008, "interrupt flood");
        put(2, 1'h0, 3);
        chk(got === 4'h0, "repeat interrupt");
        put(1, 1'h1, 3);
        chk(got === 4'h9 && relay === 16'h0000, "ack clear");
        chk(tx_kind === 4'hf && tx_id[0] === 5'h03, "ack code");
        put(1, 1'h1, 3);
        chk(got === 4'h0, "ack on clear bit");
        put(0, 1'h0, 3);
        hold(3);
        chk(len === T_ACK, "reloaded interval");
        $display("flow test done");
    endtask

    task automatic t_drop();
        ack_mode = 1'h0;
        put(0, 1'h0, 5);
        put(1, 1'h1, 5);
        chk(got === 4'h0 && relay === 16'h0020, "ack without mode");
        hold(5);
        // Counting starts three edges after the set, behind the acknowledgement's transfer
        chk(len === T_INT - 3, "interrupt mode interval");
        ack_mode = 1'h1;
        rx_ack_en = 4'hd;
        put(2, 1'h0, 6);
        put(1, 1'h1, 6);
        chk(got === 4'h0 && relay === 16'h0040, "ack rx disabled");
        put(0, 1'h1, 6);
        chk(got === 4'ha && relay === 16'h0000, "ack rx enabled");
        rx_ack_en = 4'hf;
        put(0, 1'h0, 20);
        put(0, 1'h1, 20);
        chk(got === 4'h0 && relay === 16'h0000, "absent bit");
        $display("drop test done");
    endtask

    task automatic t_enables();
        rx_int_en = 4'he;
        put(0, 1'h0, 7);
        chk(got === 4'h0 && relay === 16'h0000, "interrupt rx disabled");
        rx_int_en = 4'hf;
        tx_int_en = 4'hc;
        put(3, 1'h0, 7);
        chk(got === 4'h4 && relay === 16'h0080, "interrupt send mask");
        tx_ack_en = 4'h6;
        put(0, 1'h1, 7);
        chk(got === 4'h6 && relay === 16'h0000, "ack send mask");
        tx_int_en = 4'h7;
        tx_ack_en = 4'hb;
        $display("enable test done");
    endtask

    task automatic t_timers();
        put(0, 1'h0, 1);
        put(2, 1'h0, 2);
        for (int i = 0; i < 20 && relay[1] === 1'h1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk(relay === 16'h0004, "own timer per bit");
        nrst = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'h1;
        chk(relay === 16'h0000 && tx_valid === 4'h0 && rx_taken === 4'h0, "mid-run reset");
        @(posedge clk);
        #1;
        chk(relay === 16'h0000, "quiet after reset");
        ack_ivl = '0;
        put(0, 1'h0, 9);
        hold(9);
        chk(len === 1, "zero interval acts as one");
        ack_ivl = IAR_INTERVAL_W'(T_ACK);
        $display("timer test done");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'h1;
        @(posedge clk);
        #1;
        t_flow();
        t_drop();
        t_enables();
        t_timers();
        end_of_test();
    end
endmodule
